// [i2c_target_regs.svh]
// Offsets, field positions, reset values and timing counts of the register port
`ifndef I2C_TARGET_REGS_SVH
`define I2C_TARGET_REGS_SVH
`define OFS_OUTPUT_SETPOINT 8'h00
`define OFS_CONTROL_ONE     8'h01
`define OFS_CONTROL_TWO     8'h02
`define OFS_CONTROL_THREE   8'h03
`define OFS_STATUS          8'h04
`define RST_CONTROL_ONE     8'h2A
`define RST_CONTROL_TWO     8'h0A
`define RST_CONTROL_THREE   8'h00
`define SOFT_RESET_BIT      7
`define RAMP_LSB            0
`define RANGE_LSB           2
`define HS_CODE_MASK        8'hF8
`define HS_CODE_VALUE       8'h08
`define READ_ZERO           8'h00
`define INIT_TIME_US        400
`define CLK_MHZ             10
`define INIT_CYCLES         (`INIT_TIME_US * `CLK_MHZ)
`endif

// [i2c_target_pkg.sv]
// Types shared by the two-wire target register port
`default_nettype none
package i2c_target_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK,
		ST_READ, ST_READ_ACK
	} bus_state_t;
	typedef enum logic [1:0] {
		BYTE_DEV, BYTE_REG, BYTE_DATA
	} byte_role_t;
endpackage
`default_nettype wire

// [pin_sync.sv]
// Two-flop synchroniser with edge detection for the bus pins
`default_nettype none
module pin_sync (
	// Clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	// Raw pin and conditioned copies
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o,
	output logic      fall_o
);
	logic meta_reg;   // First stage, only read by second stage
	logic sync_reg;   // Second stage
	logic last_reg;   // Previous stable value

	// Idle bus is high, so reset to high
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			meta_reg <= 1'b1;
			sync_reg <= 1'b1;
			last_reg <= 1'b1;
		end else begin
			meta_reg <= pin_i;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level_o = sync_reg;
	assign rise_o  = sync_reg & ~last_reg;
	assign fall_o  = ~sync_reg & last_reg;
endmodule
`default_nettype wire

// [i2c_target_port.sv]
// Two-wire target interface with five-entry register map
`include "i2c_target_regs.svh"
`default_nettype none
module i2c_target_port
	import i2c_target_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR    = 7'h41, // Arbitrary default address
	parameter int         INIT_CYCLES = `INIT_CYCLES
) (
	// Clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	// Supply monitors and start-up straps
	input  wire logic       supply_above_por_i,
	input  wire logic       supply_above_undervoltage_lockout_i,
	input  wire logic       start_voltage_select_a_i,
	input  wire logic       start_voltage_select_b_i,
	input  wire logic       sync_out_strap_i,
	// Bus pins, open drain
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	// Register contents to the regulator core
	output logic [7:0]      output_setpoint_o,
	output logic [7:0]      control_one_o,
	output logic [7:0]      control_two_o,
	output logic [7:0]      control_three_o,
	output logic [1:0]      ramp_speed_o,
	output logic [1:0]      voltage_range_field_o,
	output logic [1:0]      start_voltage_sel_o,
	output logic            sync_out_strap_o,
	output logic            init_busy_o,
	output logic            high_speed_o
);
	import i2c_target_pkg::*;

	// Conditioned bus pins
	logic scl_lvl, scl_rise, scl_fall;
	logic sda_lvl, sda_rise, sda_fall;
	// Supply monitors, also asynchronous
	logic por_meta_reg, por_reg, uv_meta_reg, uv_reg;
	// Start-up sequencing
	logic        init_reg;        // Initialisation in progress
	logic        done_once_reg;   // Initialised since power-on
	logic [31:0] init_cnt_reg;    // Initialisation timer
	logic        uv_prev_reg;     // Undervoltage monitor last cycle
	// Protocol engine
	bus_state_t  state_reg;
	byte_role_t  role_reg;
	logic [2:0]  bit_cnt_reg;     // Bits left in current byte
	logic [7:0]  shift_reg;       // Incoming or outgoing byte
	logic [7:0]  ptr_reg;         // Register pointer
	logic [7:0]  wdata_reg;       // Data waiting for commit
	logic        commit_reg;      // Commit pending at ack end
	logic        hs_reg;          // High-speed mode
	logic        drive_reg;       // Pulling data low
	logic        byte_full_reg;   // Eight bits taken, decide at next fall
	// Register file
	logic [7:0]  setpoint_reg, ctrl1_reg, ctrl2_reg, ctrl3_reg;
	logic [1:0]  vsel_reg;
	logic        syncs_reg;
	logic [7:0]  status_reg;

	pin_sync u_scl (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.pin_i     (scl_i),
		.level_o   (scl_lvl),
		.rise_o    (scl_rise),
		.fall_o    (scl_fall)
	);
	pin_sync u_sda (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.pin_i     (sda_i),
		.level_o   (sda_lvl),
		.rise_o    (sda_rise),
		.fall_o    (sda_fall)
	);

	// Register read multiplexer, unmapped offsets give zero
	function automatic logic [7:0] read_mux(input logic [7:0] a,
		input logic [7:0] s, input logic [7:0] c1,
		input logic [7:0] c2, input logic [7:0] c3,
		input logic [7:0] st);
		logic [7:0] r;
		r = `READ_ZERO;
		if (a == `OFS_OUTPUT_SETPOINT) r = s;
		else if (a == `OFS_CONTROL_ONE)
			r = c1 & ~(8'h01 << `SOFT_RESET_BIT);
		else if (a == `OFS_CONTROL_TWO) r = c2;
		else if (a == `OFS_CONTROL_THREE) r = c3;
		else if (a == `OFS_STATUS) r = st;
		return r;
	endfunction

	// Bus conditions, sampled data is stable while the clock is high
	wire start_cond = sda_fall & scl_lvl;
	wire stop_cond  = sda_rise & scl_lvl;
	wire addr_match = shift_reg[7:1] == DEV_ADDR;
	wire hs_code = (shift_reg & `HS_CODE_MASK) == `HS_CODE_VALUE;
	wire [7:0] rd_byte = read_mux(ptr_reg, setpoint_reg, ctrl1_reg,
		ctrl2_reg, ctrl3_reg, status_reg);
	wire soft_rst = commit_reg & scl_fall & (ptr_reg == `OFS_CONTROL_ONE)
		& wdata_reg[`SOFT_RESET_BIT];
	wire uv_rise   = uv_reg & ~uv_prev_reg;
	wire init_go   = (uv_rise & ~done_once_reg) | soft_rst;
	wire regs_clr  = ~por_reg | soft_rst;

	// Supply monitor synchronisers
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			por_meta_reg <= 1'b0;
			por_reg      <= 1'b0;
			uv_meta_reg  <= 1'b0;
			uv_reg       <= 1'b0;
			uv_prev_reg  <= 1'b0;
		end else begin
			por_meta_reg <= supply_above_por_i;
			por_reg      <= por_meta_reg;
			uv_meta_reg  <= supply_above_undervoltage_lockout_i;
			uv_reg       <= uv_meta_reg;
			uv_prev_reg  <= uv_reg;
		end
	end

	// Start-up timer; a dip only into undervoltage does not restart it
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !por_reg) begin
			init_reg      <= 1'b0;
			done_once_reg <= 1'b0;
			init_cnt_reg  <= 32'h0;
		end else if (init_go) begin
			init_reg      <= 1'b1;
			done_once_reg <= 1'b1;
			init_cnt_reg  <= 32'(INIT_CYCLES - 1);
		end else if (init_reg) begin
			if (init_cnt_reg == 32'h0) init_reg <= 1'b0;
			else init_cnt_reg <= init_cnt_reg - 32'h1;
		end
	end

	// Straps sampled at the start of each initialisation
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			vsel_reg  <= 2'h0;
			syncs_reg <= 1'b0;
		end else if (init_go) begin
			vsel_reg  <= {start_voltage_select_b_i,
				start_voltage_select_a_i};
			syncs_reg <= sync_out_strap_i;
		end
	end

	// Protocol engine; any start or stop resynchronises it
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || init_reg) begin
			state_reg   <= ST_IDLE;
			role_reg    <= BYTE_DEV;
			bit_cnt_reg <= 3'h7;
			shift_reg   <= 8'h00;
			drive_reg   <= 1'b0;
			commit_reg  <= 1'b0;
			byte_full_reg <= 1'b0;
			hs_reg      <= 1'b0;
			wdata_reg   <= 8'h00;
			ptr_reg     <= 8'h00;
		end else if (stop_cond) begin
			state_reg <= ST_IDLE;
			drive_reg <= 1'b0;
			hs_reg    <= 1'b0;
			commit_reg <= 1'b0;
		end else if (start_cond) begin
			state_reg   <= ST_ADDR;
			bit_cnt_reg <= 3'h7;
			byte_full_reg <= 1'b0;  // The start's own clock fall is no bit
			drive_reg   <= 1'b0;
			commit_reg  <= 1'b0;
		end else begin
			case (state_reg)
			ST_IDLE: begin
				drive_reg <= 1'b0;
			end
			ST_ADDR, ST_WRITE: begin
				// Count on rises so the fall ending a start is not a bit
				if (scl_rise) begin
					shift_reg <= {shift_reg[6:0], sda_lvl};
					byte_full_reg <= (bit_cnt_reg == 3'h0);
					bit_cnt_reg <= bit_cnt_reg - 3'h1;
				end else if (scl_fall && byte_full_reg) begin
					byte_full_reg <= 1'b0;
					begin
						if (state_reg == ST_ADDR && hs_code) begin
							hs_reg    <= 1'b1;
							state_reg <= ST_IDLE;
						end else if (state_reg == ST_ADDR && !addr_match) begin
							state_reg <= ST_IDLE;
						end else begin
							drive_reg <= 1'b1;
							state_reg <= state_reg == ST_ADDR ?
								ST_ADDR_ACK : ST_WRITE_ACK;
							if (state_reg == ST_ADDR)
								role_reg <= shift_reg[0] ? BYTE_DATA : BYTE_REG;
							else if (role_reg == BYTE_REG)
								ptr_reg <= shift_reg;
							else begin
								wdata_reg  <= shift_reg;
								commit_reg <= 1'b1;
							end
						end
					end
				end
			end
			ST_ADDR_ACK, ST_WRITE_ACK: begin
				if (scl_fall) begin
					bit_cnt_reg <= 3'h7;
					commit_reg  <= 1'b0;
					if (commit_reg) ptr_reg <= ptr_reg + 8'h01;
					if (state_reg == ST_ADDR_ACK && shift_reg[0]) begin
						state_reg <= ST_READ;
						shift_reg <= rd_byte;
						drive_reg <= ~rd_byte[7];
					end else begin
						state_reg <= ST_WRITE;
						if (state_reg == ST_WRITE_ACK) role_reg <= BYTE_DATA;
						drive_reg <= 1'b0;
					end
				end
			end
			ST_READ: begin
				if (scl_fall) begin
					if (bit_cnt_reg == 3'h0) begin
						drive_reg <= 1'b0; // Release for controller ack
						state_reg <= ST_READ_ACK;
					end else begin
						shift_reg <= {shift_reg[6:0], 1'b0};
						drive_reg <= ~shift_reg[6];
					end
					bit_cnt_reg <= bit_cnt_reg - 3'h1;
				end
			end
			ST_READ_ACK: begin
				if (scl_rise && sda_lvl) begin
					state_reg <= ST_IDLE;  // Not acknowledged, stop sending
				end else if (scl_fall) begin
					ptr_reg     <= ptr_reg + 8'h01;
					shift_reg   <= read_mux(ptr_reg + 8'h01, setpoint_reg,
						ctrl1_reg, ctrl2_reg, ctrl3_reg, status_reg);
					drive_reg   <= 1'b0;
					bit_cnt_reg <= 3'h7;
					state_reg   <= ST_READ;
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Register file; write lands as the acknowledge clock falls
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || regs_clr) begin
			setpoint_reg <= 8'h00;
			ctrl1_reg    <= `RST_CONTROL_ONE;
			ctrl2_reg    <= `RST_CONTROL_TWO;
			ctrl3_reg    <= `RST_CONTROL_THREE;
		end else if (commit_reg && scl_fall && state_reg == ST_WRITE_ACK) begin
			if (ptr_reg == `OFS_OUTPUT_SETPOINT)
				setpoint_reg <= wdata_reg;
			else if (ptr_reg == `OFS_CONTROL_ONE)
				ctrl1_reg <= wdata_reg;
			else if (ptr_reg == `OFS_CONTROL_TWO)
				ctrl2_reg <= wdata_reg;
			else if (ptr_reg == `OFS_CONTROL_THREE)
				ctrl3_reg <= wdata_reg;
		end else if (init_reg && init_cnt_reg == 32'h0) begin
			setpoint_reg <= {6'h00, vsel_reg};  // start-up code
		end
	end

	// Status shows the block's own state
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) status_reg <= 8'h00;
		else status_reg <= {5'h00, hs_reg, init_reg, ~uv_reg};
	end

	// Outputs, all registered; data pin only ever pulled low
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sda_oe_o <= 1'b0;
			sda_o    <= 1'b0;
			output_setpoint_o <= 8'h00;
			control_one_o <= `RST_CONTROL_ONE;
			control_two_o <= `RST_CONTROL_TWO;
			control_three_o <= `RST_CONTROL_THREE;
			ramp_speed_o <= 2'h0;
			voltage_range_field_o <= 2'h0;
			start_voltage_sel_o <= 2'h0;
			sync_out_strap_o <= 1'b0;
			init_busy_o <= 1'b0;
			high_speed_o <= 1'b0;
		end else begin
			sda_oe_o <= drive_reg & ~stop_cond & ~start_cond;
			sda_o    <= 1'b0;
			output_setpoint_o <= setpoint_reg;
			control_one_o <= ctrl1_reg;
			control_two_o <= ctrl2_reg;
			control_three_o <= ctrl3_reg;
			ramp_speed_o <= ctrl1_reg[`RAMP_LSB +: 2];
			voltage_range_field_o <= ctrl2_reg[`RANGE_LSB +: 2];
			start_voltage_sel_o <= vsel_reg;
			sync_out_strap_o <= syncs_reg;
			init_busy_o <= init_reg;
			high_speed_o <= hs_reg;
		end
	end

	// Checks
	property p_rd_bit7_zero;
		@(posedge ref_clk_i) disable iff (rst_i)
		(ptr_reg == `OFS_CONTROL_ONE) |-> !rd_byte[`SOFT_RESET_BIT];
	endproperty
	a_rd_bit7_zero: assert property (p_rd_bit7_zero)
		else $error("soft reset bit read back as one");
	property p_unmapped_zero;
		@(posedge ref_clk_i) disable iff (rst_i)
		(ptr_reg > `OFS_STATUS) |-> rd_byte == 8'h00;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero)
		else $error("unmapped read not zero");
	property p_stop_idle;
		@(posedge ref_clk_i) disable iff (rst_i || init_reg)
		stop_cond |=> state_reg == ST_IDLE && !hs_reg;
	endproperty
	a_stop_idle: assert property (p_stop_idle)
		else $error("stop did not idle engine");
	property p_start_addr;
		@(posedge ref_clk_i) disable iff (rst_i || init_reg)
		start_cond && !stop_cond |=> state_reg == ST_ADDR;
	endproperty
	a_start_addr: assert property (p_start_addr)
		else $error("start not detected");
	property p_nomatch_noack;
		@(posedge ref_clk_i) disable iff (rst_i)
		state_reg == ST_ADDR_ACK |-> addr_match;
	endproperty
	a_nomatch_noack: assert property (p_nomatch_noack)
		else $error("acknowledged foreign address");
	property p_sreset_init;
		@(posedge ref_clk_i) disable iff (rst_i || !por_reg)
		soft_rst |=> init_reg ##1 ctrl1_reg == `RST_CONTROL_ONE;
	endproperty
	a_sreset_init: assert property (p_sreset_init)
		else $error("soft reset did not restart");
	property p_range_out;
		@(posedge ref_clk_i) disable iff (rst_i)
		1'b1 |=> voltage_range_field_o == $past(ctrl2_reg[3:2]);
	endproperty
	a_range_out: assert property (p_range_out)
		else $error("range field not forwarded");
	property p_hs_noack;
		@(posedge ref_clk_i) disable iff (rst_i || init_reg)
		$rose(hs_reg) |-> !drive_reg;
	endproperty
	a_hs_noack: assert property (p_hs_noack)
		else $error("master code acknowledged");
endmodule
`default_nettype wire

// [i2c_ctl_model.sv]
// Bus controller model that drives the target port's two-wire bus
`default_nettype none
module i2c_ctl_model (
	// Bus lines, open drain
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// Idle bus: clock stands high, data released
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// Start or repeated start: data falls while clock is high
	// Clock rises only after the target has let go of its acknowledge,
	// otherwise the release would look like a stop
	task automatic start();
		sda_low_o = 1'b0;
		#600 scl_o = 1'b1;
		#300 sda_low_o = 1'b1;
		#300 scl_o = 1'b0;
	endtask

	// Stop: data rises while clock is high, then clock stays high
	task automatic stop();
		sda_low_o = 1'b1;
		#200 scl_o = 1'b1;
		#300 sda_low_o = 1'b0;
		#300;
	endtask

	// One pulse: data set mid low phase, held through the high phase
	task automatic bit_io(input logic d, output logic q);
		#200 sda_low_o = ~d;
		#300 scl_o = 1'b1;
		#200 q = sda_i;
		#100 scl_o = 1'b0;
	endtask

	// Byte MSB first plus acknowledge slot; 1 bits release the line
	task automatic xfer(input logic [7:0] tx, input logic mack,
			output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(mack, ack);
	endtask

	// Single register update; offsets stay inside the map
	task automatic wr(input logic [7:0] dev, input logic [7:0] ofs,
			input logic [7:0] dat, output logic [2:0] acks);
		logic [7:0] rx;
		start();
		xfer(dev, 1'b1, rx, acks[2]);
		xfer(ofs, 1'b1, rx, acks[1]);
		xfer(dat, 1'b1, rx, acks[0]);
		stop();
	endtask

	// Pointer write, repeated start, one byte read ending in no-ack
	task automatic rd(input logic [7:0] dev, input logic [7:0] ofs,
			output logic [7:0] dat);
		logic a;
		start();
		xfer(dev, 1'b1, dat, a);
		xfer(ofs, 1'b1, dat, a);
		start();
		xfer(dev | 8'h01, 1'b1, dat, a);
		xfer(8'hFF, 1'b1, dat, a);
		stop();
	endtask
endmodule
`default_nettype wire

// [testbench.sv]
// Self-checking bench for the two-wire target register port
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	// Address byte of the target, write direction
	localparam logic [7:0] WA = 8'h82;
	// Clock, reset, supplies and straps
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic por = 1'b1;
	logic undervoltage_lockout = 1'b0;
	logic sel_a = 1'b1;
	logic sel_b = 1'b0;
	logic sync_in = 1'b1;
	// Bus wires; line is pulled up unless someone pulls it low
	wire scl;
	wire sda_low;
	logic sda_drv;
	logic sda_oe;
	wire sda_line = ~(sda_low | (sda_oe & ~sda_drv));
	// Register copies and status outputs
	logic [7:0] setp, c1, c2, c3;
	logic [1:0] ramp, rng, ssel;
	logic sync_s, busy, hs;
	// Expected read-back after start-up, offset 5 unmapped
	logic [7:0] dflt [6] = '{8'h01, 8'h2A, 8'h0A, 8'h00, 8'h00, 8'h00};
	// Range codes, each a step to an adjacent range
	logic [1:0] rseq [5] = '{2'd1, 2'd0, 2'd1, 2'd2, 2'd3};
	int num_errors = 0;
	int n_tests = 0;

	`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin \
		num_errors++; $display("unexpected at %0t: %h %h", $time, g, e); end end

	// 10 MHz reference clock
	always #50 ref_clk_i = ~ref_clk_i;

	i2c_target_port #(.DEV_ADDR(7'h41), .INIT_CYCLES(20)) DUT (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.supply_above_por_i(por), .supply_above_undervoltage_lockout_i(undervoltage_lockout),
		.start_voltage_select_a_i(sel_a),
		.start_voltage_select_b_i(sel_b),
		.sync_out_strap_i(sync_in),
		.scl_i(scl), .sda_i(sda_line), .sda_o(sda_drv),
		.sda_oe_o(sda_oe), .output_setpoint_o(setp),
		.control_one_o(c1), .control_two_o(c2), .control_three_o(c3),
		.ramp_speed_o(ramp), .voltage_range_field_o(rng),
		.start_voltage_sel_o(ssel), .sync_out_strap_o(sync_s),
		.init_busy_o(busy), .high_speed_o(hs));

	i2c_ctl_model ctl (.sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));

	// Verdict and end of run
	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Bounded wait for the init flag; counts cycles spent
	task automatic wait_busy(input logic v, output int n);
		for (n = 0; busy !== v; n++) begin
			if (n == 300) begin
				num_errors++;
				end_of_test();
			end
			@(negedge ref_clk_i);
		end
	endtask

	// Main sequence, driven on falling clock edges
	initial begin
		logic [7:0] d;
		logic [2:0] a;
		int n;
		repeat (12) @(negedge ref_clk_i);
		rst_i = 1'b0;
		@(negedge ref_clk_i);
		`CHK(c2, 8'h0A)
		ctl.stop();
		undervoltage_lockout = 1'b1;
		wait_busy(1'b1, n);
		wait_busy(1'b0, n);
		`CHK(n inside {[19:22]}, 1'b1)
		`CHK(ssel, 2'b01)
		`CHK(sync_s, 1'b1)
		// Dip below undervoltage only: no second init
		undervoltage_lockout = 1'b0;
		repeat (10) @(negedge ref_clk_i);
		undervoltage_lockout = 1'b1;
		repeat (10) @(negedge ref_clk_i);
		`CHK(busy, 1'b0)
		for (int i = 0; i < 6; i++) begin
			ctl.rd(WA, 8'(i), d);
			`CHK(d, dflt[i])
		end
		ctl.wr(8'h84, 8'h00, 8'h77, a);
		`CHK(a, 3'b111)
		ctl.wr(WA, 8'h00, 8'h5A, a);
		`CHK(a, 3'b000)
		`CHK(setp, 8'h5A)
		ctl.wr(WA, 8'h01, 8'h2B, a);
		`CHK(ramp, 2'b11)
		foreach (rseq[i]) begin
			ctl.wr(WA, 8'h02, {4'h0, rseq[i], 2'b10}, a);
			ctl.wr(WA, 8'h00, 8'h40, a);
			`CHK(rng, rseq[i])
		end
		// Master code, then repeated start inside high-speed mode
		ctl.start();
		ctl.xfer(8'h0B, 1'b1, d, a[0]);
		`CHK(a[0], 1'b1)
		repeat (5) @(negedge ref_clk_i);
		`CHK(hs, 1'b1)
		ctl.rd(WA, 8'h04, d);
		`CHK(d, 8'h04)
		repeat (5) @(negedge ref_clk_i);
		`CHK(hs, 1'b0)
		// Soft reset restores defaults and restarts
		ctl.wr(WA, 8'h03, 8'h5C, a);
		`CHK(c3, 8'h5C)
		ctl.wr(WA, 8'h01, 8'h80, a);
		wait_busy(1'b1, n);
		wait_busy(1'b0, n);
		`CHK(c3, 8'h00)
		ctl.rd(WA, 8'h01, d);
		`CHK(d, 8'h2A)
		// Supply collapse clears registers; new straps at re-init
		ctl.wr(WA, 8'h03, 8'h5C, a);
		por = 1'b0;
		undervoltage_lockout = 1'b0;
		sel_a = 1'b0;
		sel_b = 1'b1;
		sync_in = 1'b0;
		repeat (8) @(negedge ref_clk_i);
		`CHK(c3, 8'h00)
		por = 1'b1;
		repeat (3) @(negedge ref_clk_i);
		undervoltage_lockout = 1'b1;
		wait_busy(1'b1, n);
		wait_busy(1'b0, n);
		`CHK(setp, 8'h02)
		`CHK(ssel, 2'b10)
		`CHK(sync_s, 1'b0)
		end_of_test();
	end
endmodule
`default_nettype wire
